/* File: hw/clock_select_pkg.sv */
// constants, modes and carrier types for the system clock source select block
// assumes a 25 MHz register clock and an APB master with 32-bit data
package clock_select_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CLOCK_SOURCE_CONTROL_ADDR = 12'h000;
    localparam logic [11:0] CONFIG_HIGH_BYTE_ADDR     = 12'h004;
    localparam logic [11:0] SECONDARY_TIMER_ADDR      = 12'h008;
    localparam logic [11:0] CLOCK_STATUS_ADDR         = 12'h00C;
    localparam int          SCS_BIT                   = 0;
    localparam int          OSC_ENABLE_BIT            = 0;
    localparam int          CFG_MODE_LSB              = 0;
    localparam int          CFG_SWITCH_BIT            = 3;
    localparam int          STAT_RUN_BIT              = 0;
    localparam int          STAT_PLL_BIT              = 1;
    localparam int          STAT_SECONDARY_BIT        = 2;
    localparam int          STAT_SWITCHING_BIT        = 3;
    localparam int          STAT_MODE_LSB             = 4;
    localparam logic [2:0]  MODE_RESET                = 3'h0;
    localparam logic        SWITCH_ENABLE_N_RESET     = 1'b1;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_FREQ_HZ          = 25_000_000;
    localparam int          PLL_LOCK_US          = 2000;
    localparam int          PLL_LOCK_CYCLES      = CLK_FREQ_HZ / 1_000_000 * PLL_LOCK_US;
    localparam int          SYNC_EDGES           = 8;
    localparam int          DIVIDE_BY            = 4;
    localparam logic [1:0]  LAST_QUARTER         = 2'h3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LOW_POWER_CRYSTAL_MODE     = 3'b000,
        STANDARD_CRYSTAL_MODE      = 3'b001,
        HIGH_SPEED_CRYSTAL_MODE    = 3'b010,
        PLL_X4_MODE                = 3'b011,
        RESISTOR_CAPACITOR_OSC_MODE = 3'b100,
        RESISTOR_CAPACITOR_IO_MODE = 3'b101,
        EXTERNAL_CLOCK_MODE        = 3'b110,
        EXTERNAL_CLOCK_IO_MODE     = 3'b111
    } osc_mode_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_request_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_answer_type;

endpackage : clock_select_pkg

/* File: hw/edge_counter.sv */
// counts rising edges of a sampled clock input, reports when a count is reached
// assumes the sampled clock is synchronous to clk and slower than clk / 2
`timescale 1ns/1ns
module edge_counter (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic start,
    input  wire logic sampledClock,
    output logic      done
);
    logic [3:0] count;
    logic [3:0] next_count;
    logic       lastLevel;
    logic       next_lastLevel;
    logic       next_done;
    logic       rising;

    always_comb begin
        rising         = sampledClock && !lastLevel;
        next_lastLevel = sampledClock;
        next_count     = count;
        next_done      = 1'b0;
        if (start) begin
            next_count = '0;
        end else if (rising && count != 4'(clock_select_pkg::SYNC_EDGES)) begin
            next_count = count + 4'h1;
            next_done  = (count == 4'(clock_select_pkg::SYNC_EDGES - 1));
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count     <= 4'(clock_select_pkg::SYNC_EDGES);
            lastLevel <= 1'b0;
            done      <= 1'b0;
        end else begin
            count     <= next_count;
            lastLevel <= next_lastLevel;
            done      <= next_done;
        end
    end

    property p_done_after_edges;
        @(posedge clk) disable iff (!resetn)
            done |-> $past(count) == 4'(clock_select_pkg::SYNC_EDGES - 1);
    endproperty
    a_done_after_edges: assert property (p_done_after_edges)
        else $error("switch done without eight edges");

endmodule : edge_counter

/* File: hw/quarter_divider.sv */
// divides the primary clock input by four and tracks the quarter phase
// assumes the primary clock input is sampled synchronously to clk
`timescale 1ns/1ns
module quarter_divider (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       sourceClock,
    output logic [1:0]      phase,
    output logic            divided
);
    logic       lastLevel;
    logic [1:0] next_phase;
    logic       next_divided;

    always_comb begin
        next_phase   = phase;
        next_divided = divided;
        if (sourceClock && !lastLevel) begin
            next_phase   = phase + 2'h1;
            next_divided = (next_phase >= 2'(clock_select_pkg::DIVIDE_BY / 2));
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lastLevel <= 1'b0;
            phase     <= 2'h0;
            divided   <= 1'b0;
        end else begin
            lastLevel <= sourceClock;
            phase     <= next_phase;
            divided   <= next_divided;
        end
    end

    property p_divided_phase;
        @(posedge clk) disable iff (!resetn)
            $rose(divided) |-> phase == 2'(clock_select_pkg::DIVIDE_BY / 2);
    endproperty
    a_divided_phase: assert property (p_divided_phase)
        else $error("divided output rose off the half-count phase");

endmodule : quarter_divider

/* File: hw/system_clock_source_select.sv */
// system clock source select: oscillator mode, clock-out pin, pll lock, switching
// assumes clock pins are sampled on clk; apb master per the amba rules
// Operation
// - rc mode drives clock-out pin with oscillator divided by four
// - rc io mode: clock-out pin becomes port a bit 6
// - external clock mode drives clock-out pin with input divided by four
// - external clock io mode: clock-out pin becomes port a bit 6
// - external clock modes apply no start-up delay
// - pll mode multiplies incoming crystal frequency by four
// - pll enabled only in pll mode; otherwise clock comes from input pin
// - oscillator mode fixed by three-bit configuration field
// - execution held until pll lock timer expires
// - switching only when enable configuration bit is zero
// - select bit zero picks primary, one picks secondary oscillator
// - every reset clears the system clock select bit
// - secondary oscillator off: select writes ignored, bit forced zero
// - select settable only with switching enabled and secondary running
// - control register bits 7 to 1 read as zero
// - eight primary oscillator modes from three configuration bits
// - count eight target clock edges before using it; code counts only secondary edges, return to primary has no count
// - freeze at first quarter phase until synchronisation finishes; cpuRun drops one clk after select is set, count starts at phase 3 (LAST_QUARTER)
`timescale 1ns/1ns
module system_clock_source_select #(
    parameter int          PLL_LOCK_CYCLES = clock_select_pkg::PLL_LOCK_CYCLES,
    parameter logic [23:0] MODE_MAP        = 24'hFA_C688
) (
    input  wire logic                              clk,
    input  wire logic                              resetn,
    input  wire clock_select_pkg::apb_request_type apbRequest,
    output clock_select_pkg::apb_answer_type       apbAnswer,
    input  wire logic                              clockInPin,
    input  wire logic                              secondaryClockPin,
    input  wire logic                              portABit6Out,
    input  wire logic                              portABit6OutEnableN,
    output logic                                   clockOutPin,
    output logic                                   clockOutEnableN,
    output logic                                   pllEnable,
    output logic                                   secondaryActive,
    output logic                                   cpuRun,
    output logic                                   startupDelayUsed
);
    typedef enum logic [2:0] {
        ST_LOCK     = 3'b000,
        ST_RUN      = 3'b001,
        ST_WAIT_Q1  = 3'b010,
        ST_SYNC     = 3'b011,
        ST_RUN_SEC  = 3'b100
    } switch_state_type;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // code to mode map
    function automatic clock_select_pkg::osc_mode_type decode_mode(input logic [2:0] code);
        decode_mode = clock_select_pkg::osc_mode_type'(MODE_MAP[code * 3 +: 3]);
    endfunction : decode_mode
    function automatic logic is_io_mode(input clock_select_pkg::osc_mode_type mode);
        is_io_mode = (mode == clock_select_pkg::RESISTOR_CAPACITOR_IO_MODE)
                  || (mode == clock_select_pkg::EXTERNAL_CLOCK_IO_MODE);
    endfunction : is_io_mode
    function automatic logic is_div_mode(input clock_select_pkg::osc_mode_type mode);
        is_div_mode = (mode == clock_select_pkg::RESISTOR_CAPACITOR_OSC_MODE)
                   || (mode == clock_select_pkg::EXTERNAL_CLOCK_MODE);
    endfunction : is_div_mode

    logic [2:0]                    oscModeCfg;
    logic                          clockSwitchEnableNCfg;
    logic                          secondaryOscEnable;
    logic                          systemClockSelect;
    logic                          configLocked;
    clock_select_pkg::osc_mode_type mode;
    switch_state_type              state;
    logic [23:0]                   lockCount;
    logic                          syncStart, syncDone;
    logic [1:0]                    phase;
    logic                          divided, targetClock;

    logic [2:0]       next_oscModeCfg;
    logic             next_clockSwitchEnableNCfg, next_secondaryOscEnable;
    logic             next_systemClockSelect, next_configLocked;
    switch_state_type next_state;
    logic [23:0]      next_lockCount;
    logic             next_syncStart;
    clock_select_pkg::apb_answer_type next_apbAnswer;
    logic             next_clockOutPin, next_clockOutEnableN;
    logic             next_pllEnable, next_secondaryActive;
    logic             next_cpuRun, next_startupDelayUsed;
    logic             access, switchAllowed;

    assign mode = decode_mode(oscModeCfg);

    quarter_divider divider (
        .clk         (clk),
        .resetn      (resetn),
        .sourceClock (clockInPin),
        .phase       (phase),
        .divided     (divided)
    );

    assign targetClock = (state == ST_WAIT_Q1 || state == ST_SYNC) ? secondaryClockPin
                                                                    : clockInPin;
    edge_counter syncCounter (
        .clk          (clk),
        .resetn       (resetn),
        .start        (syncStart),
        .sampledClock (targetClock),
        .done         (syncDone)
    );

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb begin
        access                     = apbRequest.psel && apbRequest.penable;
        next_oscModeCfg            = oscModeCfg;
        next_clockSwitchEnableNCfg = clockSwitchEnableNCfg;
        next_secondaryOscEnable    = secondaryOscEnable;
        next_configLocked          = configLocked;
        next_systemClockSelect     = systemClockSelect;
        next_apbAnswer             = '0;
        next_apbAnswer.pready      = access && !apbAnswer.pready;
        if (access && !apbAnswer.pready) begin
            unique case (apbRequest.paddr)
                clock_select_pkg::CLOCK_SOURCE_CONTROL_ADDR: begin
                    next_apbAnswer.prdata[clock_select_pkg::SCS_BIT] = systemClockSelect;
                    if (apbRequest.pwrite) begin
                        next_systemClockSelect = apbRequest.pwdata[clock_select_pkg::SCS_BIT];
                    end
                end
                clock_select_pkg::CONFIG_HIGH_BYTE_ADDR: begin
                    next_apbAnswer.prdata[clock_select_pkg::CFG_MODE_LSB +: 3] = oscModeCfg;
                    next_apbAnswer.prdata[clock_select_pkg::CFG_SWITCH_BIT] =
                        clockSwitchEnableNCfg;
                    if (apbRequest.pwrite && !configLocked) begin
                        next_oscModeCfg = apbRequest.pwdata[clock_select_pkg::CFG_MODE_LSB +: 3];
                        next_clockSwitchEnableNCfg =
                            apbRequest.pwdata[clock_select_pkg::CFG_SWITCH_BIT];
                        next_configLocked = 1'b1;
                    end
                end
                clock_select_pkg::SECONDARY_TIMER_ADDR: begin
                    next_apbAnswer.prdata[clock_select_pkg::OSC_ENABLE_BIT] = secondaryOscEnable;
                    if (apbRequest.pwrite) begin
                        next_secondaryOscEnable =
                            apbRequest.pwdata[clock_select_pkg::OSC_ENABLE_BIT];
                    end
                end
                clock_select_pkg::CLOCK_STATUS_ADDR: begin
                    next_apbAnswer.prdata[clock_select_pkg::STAT_RUN_BIT]       = cpuRun;
                    next_apbAnswer.prdata[clock_select_pkg::STAT_PLL_BIT]       = pllEnable;
                    next_apbAnswer.prdata[clock_select_pkg::STAT_SECONDARY_BIT] =
                        secondaryActive;
                    next_apbAnswer.prdata[clock_select_pkg::STAT_SWITCHING_BIT] =
                        (state == ST_WAIT_Q1) || (state == ST_SYNC);
                    next_apbAnswer.prdata[clock_select_pkg::STAT_MODE_LSB +: 3] = mode;
                end
                default: begin
                    next_apbAnswer.pslverr = 1'b1;
                end
            endcase
        end
        switchAllowed = !next_clockSwitchEnableNCfg && next_secondaryOscEnable;
        if (!switchAllowed) begin
            next_systemClockSelect = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // switching and lock sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_lockCount = lockCount;
        next_syncStart = 1'b0;
        unique case (state)
            // hold until lock, no delay otherwise
            ST_LOCK: begin
                if (mode != clock_select_pkg::PLL_X4_MODE || lockCount == 24'h00_0000) begin
                    next_state = configLocked ? ST_RUN : ST_LOCK;
                end else begin
                    next_lockCount = lockCount - 24'h00_0001;
                end
            end
            ST_RUN: begin
                if (systemClockSelect) begin
                    next_state = ST_WAIT_Q1;
                end
            end
            ST_WAIT_Q1: begin
                if (!systemClockSelect) begin
                    next_state = ST_RUN;
                end else if (phase == clock_select_pkg::LAST_QUARTER) begin
                    next_state     = ST_SYNC;
                    next_syncStart = 1'b1;
                end
            end
            ST_SYNC: begin
                if (!systemClockSelect) begin
                    next_state = ST_RUN;
                end else if (syncDone) begin
                    next_state = ST_RUN_SEC;
                end
            end
            ST_RUN_SEC: begin
                if (!systemClockSelect) begin
                    next_state     = ST_LOCK;
                    next_lockCount = 24'(PLL_LOCK_CYCLES);
                end
            end
            default: begin
                next_state = ST_LOCK;
            end
        endcase
        next_secondaryActive = (next_state == ST_RUN_SEC);
        next_cpuRun          = (next_state == ST_RUN) || (next_state == ST_RUN_SEC);
        next_pllEnable       = (mode == clock_select_pkg::PLL_X4_MODE);
        next_startupDelayUsed = (next_state == ST_LOCK) && next_pllEnable;
        next_clockOutPin     = 1'b0;
        next_clockOutEnableN = 1'b1;
        if (is_div_mode(mode)) begin
            next_clockOutPin     = divided;
            next_clockOutEnableN = 1'b0;
        end else if (is_io_mode(mode)) begin
            next_clockOutPin     = portABit6Out;
            next_clockOutEnableN = portABit6OutEnableN;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            oscModeCfg            <= clock_select_pkg::MODE_RESET;
            clockSwitchEnableNCfg <= clock_select_pkg::SWITCH_ENABLE_N_RESET;
            secondaryOscEnable    <= 1'b0;
            configLocked          <= 1'b0;
            systemClockSelect     <= 1'b0;
            state                 <= ST_LOCK;
            lockCount             <= 24'(PLL_LOCK_CYCLES);
            syncStart             <= 1'b0;
            apbAnswer             <= '0;
            clockOutPin           <= 1'b0;
            clockOutEnableN       <= 1'b1;
            pllEnable             <= 1'b0;
            secondaryActive       <= 1'b0;
            cpuRun                <= 1'b0;
            startupDelayUsed      <= 1'b0;
        end else begin
            oscModeCfg            <= next_oscModeCfg;
            clockSwitchEnableNCfg <= next_clockSwitchEnableNCfg;
            secondaryOscEnable    <= next_secondaryOscEnable;
            configLocked          <= next_configLocked;
            systemClockSelect     <= next_systemClockSelect;
            state                 <= next_state;
            lockCount             <= next_lockCount;
            syncStart             <= next_syncStart;
            apbAnswer             <= next_apbAnswer;
            clockOutPin           <= next_clockOutPin;
            clockOutEnableN       <= next_clockOutEnableN;
            pllEnable             <= next_pllEnable;
            secondaryActive       <= next_secondaryActive;
            cpuRun                <= next_cpuRun;
            startupDelayUsed      <= next_startupDelayUsed;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_select_gated;
        @(posedge clk) disable iff (!resetn)
            systemClockSelect |-> !clockSwitchEnableNCfg && secondaryOscEnable;
    endproperty
    a_select_gated: assert property (p_select_gated)
        else $error("select set while switching not allowed");
    property p_osc_off_clears;
        @(posedge clk) disable iff (!resetn)
            !secondaryOscEnable |-> !systemClockSelect;
    endproperty
    a_osc_off_clears: assert property (p_osc_off_clears)
        else $error("select set with secondary oscillator off");
    property p_pll_mode_only;
        @(posedge clk) disable iff (!resetn)
            ##1 pllEnable == ($past(mode) == clock_select_pkg::PLL_X4_MODE);
    endproperty
    a_pll_mode_only: assert property (p_pll_mode_only)
        else $error("pll enable does not match mode");
    property p_secondary_needs_select;
        @(posedge clk) disable iff (!resetn)
            secondaryActive |-> $past(systemClockSelect);
    endproperty
    a_secondary_needs_select: assert property (p_secondary_needs_select)
        else $error("secondary source without select");
    property p_io_mode_pin;
        @(posedge clk) disable iff (!resetn)
            is_io_mode($past(mode)) |-> clockOutEnableN == $past(portABit6OutEnableN);
    endproperty
    a_io_mode_pin: assert property (p_io_mode_pin)
        else $error("io mode pin not handed to port");
    property p_div_mode_drive;
        @(posedge clk) disable iff (!resetn)
            is_div_mode($past(mode)) |-> !clockOutEnableN && clockOutPin == $past(divided);
    endproperty
    a_div_mode_drive: assert property (p_div_mode_drive)
        else $error("divided clock not driven");
    property p_no_run_in_lock;
        @(posedge clk) disable iff (!resetn)
            (state == ST_LOCK && lockCount != 24'h00_0000
             && mode == clock_select_pkg::PLL_X4_MODE) |=> !cpuRun;
    endproperty
    a_no_run_in_lock: assert property (p_no_run_in_lock)
        else $error("execution before pll lock");
    property p_ext_no_delay;
        @(posedge clk) disable iff (!resetn)
            (state == ST_LOCK && mode == clock_select_pkg::EXTERNAL_CLOCK_MODE)
                |=> state == ST_RUN;
    endproperty
    a_ext_no_delay: assert property (p_ext_no_delay)
        else $error("start-up delay in external clock mode");
    property p_frozen_in_sync;
        @(posedge clk) disable iff (!resetn)
            (state == ST_SYNC && !syncDone && systemClockSelect) |=> !cpuRun;
    endproperty
    a_frozen_in_sync: assert property (p_frozen_in_sync)
        else $error("processor ran during synchronisation");

endmodule : system_clock_source_select

/* File: verification/osc_source.sv */
// partner: primary and secondary oscillator inputs
// assumes both run well below half the bench clock
`timescale 1ns/1ns
module osc_source (
    input  wire logic clk,
    output logic      primary,
    output logic      secondary
);
    logic [3:0] count = 4'h0;
    always @(posedge clk) count <= count + 4'h1;
    assign primary = count[1];
    assign secondary = count[3];
endmodule : osc_source

/* File: verification/system_clock_source_select_test.sv */
// bench for the system clock source select block
// assumes apb answers before the watchdog expires; osc_source feeds the clock pins
`timescale 1ns/1ns
module system_clock_source_select_test;
    localparam logic [11:0] CTL = clock_select_pkg::CLOCK_SOURCE_CONTROL_ADDR;
    logic clk = 1'b0, resetn = 1'b0, pOut = 1'b0, pEnN = 1'b1, err, last, sawDly, froze;
    logic pin, sec, cOut, cEnN, pll, sAct, run, dly;
    logic [31:0] rd, cfg;
    clock_select_pkg::apb_request_type req = '0;
    clock_select_pkg::apb_answer_type  ans;
    int num_errors = 0, total_checks = 0, seed = 32'h03c3_aaf2, rises;
    always #20 clk = ~clk;
    osc_source src (.clk(clk), .primary(pin), .secondary(sec));
    system_clock_source_select #(.PLL_LOCK_CYCLES(20)) dut (.clk(clk), .resetn(resetn),
        .apbRequest(req), .apbAnswer(ans), .clockInPin(pin), .secondaryClockPin(sec),
        .portABit6Out(pOut), .portABit6OutEnableN(pEnN), .clockOutPin(cOut),
        .clockOutEnableN(cEnN), .pllEnable(pll), .secondaryActive(sAct), .cpuRun(run),
        .startupDelayUsed(dly));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        while (ans.pready !== 1'b1) @(posedge clk);
        rd = ans.prdata;
        err = ans.pslverr;
        req <= '0;
    endtask : apb
    task automatic restart();
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
    endtask : restart
    function automatic logic expEnN(int m, logic en);
        return (m == 4 || m == 6) ? 1'b0 : (m == 5 || m == 7) ? en : 1'b1;
    endfunction : expEnN
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        #400_000;
        num_errors++;
        test_done();
    end
    initial begin
        for (int m = 0; m < 8; m++) begin
            restart();
            apb(1'b0, CTL, 32'h0000_0000);
            chk("ctl reset", 32'h0000_0000, rd);
            cfg = 32'(m) | ((m == 3) ? 32'h0000_0008 : 32'h0000_0000);
            apb(1'b1, clock_select_pkg::CONFIG_HIGH_BYTE_ADDR, cfg);
            pOut <= 1'($random(seed));
            pEnN <= 1'($random(seed));
            rises = 0;
            sawDly = 1'b0;
            @(posedge clk);
            last = cOut;
            repeat (128) begin
                @(posedge clk);
                sawDly |= dly;
                rises += int'(cOut && !last);
                last = cOut;
            end
            chk("pll", m == 3, pll);
            chk("out enable", expEnN(m, pEnN), cEnN);
            if (m == 5 || m == 7) chk("port data", pOut, cOut);
            if (m == 4 || m == 6) chk("divided", 8, rises);
            if (m == 3 || m >= 6) chk("delay", m == 3, sawDly);
            chk("run", 1, run);
            apb(1'b0, clock_select_pkg::CLOCK_STATUS_ADDR, 32'h0000_0000);
            chk("mode", m, (rd >> 4) & 7);
            if (m == 3 || m == 6) begin
                apb(1'b1, CTL, 32'hFFFF_FFFF);
                apb(1'b0, CTL, 32'h0000_0000);
                chk("select off", 0, rd);
                apb(1'b1, clock_select_pkg::SECONDARY_TIMER_ADDR, 32'h0000_0001);
                apb(1'b1, CTL, 32'hFFFF_FFFF);
                froze = 1'b0;
                for (int n = 0; n < 400 && sAct !== 1'b1; n++) begin
                    @(posedge clk);
                    froze |= !run;
                end
                apb(1'b0, CTL, 32'h0000_0000);
                chk("select", m == 6, rd);
                chk("secondary", m == 6, sAct);
                chk("frozen", m == 6, froze);
            end
        end
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped", 1, err);
        test_done();
    end
endmodule : system_clock_source_select_test
